// >>> design/pin_select_params.svh
// offsets, field positions, reset values and encodings for the pin-function block
// assumes a 32-bit AXI4-Lite slave whose byte address is four times the register index
`ifndef PIN_SELECT_PARAMS_SVH
`define PIN_SELECT_PARAMS_SVH

// register indices as printed; byte address is the index shifted left by two
`define PORT_C_OUTPUT_LATCH_IDX       18'h0FA41
`define UPPER_PIN_FUNCTION_SELECT_IDX 18'h0FA46
`define PORT_C_OUTPUT_LATCH_ADDR       {`PORT_C_OUTPUT_LATCH_IDX, 2'b00}
`define UPPER_PIN_FUNCTION_SELECT_ADDR {`UPPER_PIN_FUNCTION_SELECT_IDX, 2'b00}
`define REG_ADDR_W 20

// implemented bits and reset values
`define UPPER_SEL_MASK   16'h03FF
`define UPPER_SEL_RESET  16'h03FF
`define PORT_C_MASK      8'h7F
`define PORT_C_RESET     8'h7F

// selector field layout: pin n (0 = select six .. 4 = select ten) at bits 2n+1:2n
`define SEL_FIELD_W      2
`define UPPER_PIN_COUNT  5
`define STRAP_FIRST_BIT  3
`define BOOT_WIDTH_BIT   0
`define DISCRETE_PC_BASE 3

// selector encodings
`define SEL_DISCRETE  2'b00
`define SEL_ALTERNATE 2'b01
`define SEL_CS_8BIT   2'b10
`define SEL_CS_16BIT  2'b11

// bus answers
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> design/pin_select_pkg.sv
// types shared by the pin-function block, its pin mux and the interface between them
// assumes pin_select_params.svh is on the include path
`include "pin_select_params.svh"

package pin_select_pkg;

  typedef logic [`SEL_FIELD_W-1:0] pin_sel_t;

  typedef pin_sel_t [`UPPER_PIN_COUNT-1:0] pin_sel_array_t;

  // strap capture sequence around the release of reset
  typedef enum logic [1:0] {
    ST_IN_RESET,
    ST_LOAD,
    ST_RUN
  } strap_state_e;

endpackage

// >>> design/pin_drive_if.sv
// signals between the register side of the pin-function block and its pin mux
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_params.svh"

interface pin_drive_if;
  import pin_select_pkg::*;

  pin_sel_array_t                   sel;
  logic [6:0]                       port_c;
  logic                             e_clock;
  logic [`UPPER_PIN_COUNT-1:0]      addr_high;
  logic [`UPPER_PIN_COUNT-1:0]      match;
  logic [`UPPER_PIN_COUNT-1:0]      pin_out;
  logic [`UPPER_PIN_COUNT-1:0]      port_16;

  modport ctrl (
    output sel,
    output port_c,
    output e_clock,
    output addr_high,
    output match,
    input  pin_out,
    input  port_16
  );

  modport mux (
    input  sel,
    input  port_c,
    input  e_clock,
    input  addr_high,
    input  match,
    output pin_out,
    output port_16
  );

endinterface

`default_nettype wire

// >>> design/pin_function_mux.sv
// per-pin function selection for the five upper chip-select pins
// assumes selector fields, port c latch and match strobes arrive on the aclk domain
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_params.svh"

module pin_function_mux
  import pin_select_pkg::*;
#(
  parameter int                          PIN_COUNT    = 5,
  // pins that own a discrete output; all five upper pins do
  parameter logic [`UPPER_PIN_COUNT-1:0] HAS_DISCRETE = 5'h1F
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register side
  pin_drive_if.mux pins
);

  if (PIN_COUNT != `UPPER_PIN_COUNT) begin : g_bad_pin_count
    $error("pin_function_mux serves exactly five pins");
  end

  wire [PIN_COUNT-1:0] next_pin_out;
  wire [PIN_COUNT-1:0] next_port_16;
  wire [PIN_COUNT-1:0] discrete_val;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      // the top pin shows the bus e-clock instead of a port c bit
      if (i == PIN_COUNT - 1) begin : g_bus_e_clock_out
        assign discrete_val[i] = pins.e_clock;
      end else begin : g_pc
        assign discrete_val[i] = pins.port_c[i + `DISCRETE_PC_BASE];
      end
      wire is_disc = (pins.sel[i] == `SEL_DISCRETE) && HAS_DISCRETE[i];
      wire is_alt  = (pins.sel[i] == `SEL_ALTERNATE) ||
                     ((pins.sel[i] == `SEL_DISCRETE) && !HAS_DISCRETE[i]);
      // chip-select is active low while the address match fires
      assign next_pin_out[i] = is_disc ? discrete_val[i] :
                               is_alt  ? pins.addr_high[i] :
                                         !pins.match[i];
      assign next_port_16[i] = (pins.sel[i] == `SEL_CS_16BIT);
    end
  endgenerate

  // registered so the pins never glitch while the selector changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins.pin_out <= '1;
      pins.port_16 <= '0;
    end else begin
      pins.pin_out <= next_pin_out;
      pins.port_16 <= next_port_16;
    end
  end

endmodule

`default_nettype wire

// >>> design/chip_select_pin_assignment.sv
// register side of the upper chip-select pin functions and the port c output latch
// assumes an AXI4-Lite master on aclk, address-match strobes from the chip-select
// comparators on aclk, and data-bus strap levels arriving from pins
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_params.svh"

module chip_select_pin_assignment
  import pin_select_pkg::*;
#(
  parameter int ADDR_W = `REG_ADDR_W
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  // axi4-lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // axi4-lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // axi4-lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  // axi4-lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // reset straps and mode
  input  wire logic [7:0]                  data_bus_strap,
  input  wire logic                        mode_8bit_expanded,
  // pin sources
  input  wire logic                        bus_e_clock_out,
  input  wire logic [`UPPER_PIN_COUNT-1:0] addr_high_in,
  input  wire logic [`UPPER_PIN_COUNT-1:0] cs_match,
  input  wire logic                        boot_match,
  // pins and status
  output logic [`UPPER_PIN_COUNT-1:0]      cs_pin_out,
  output logic [`UPPER_PIN_COUNT-1:0]      cs_port_16,
  output logic                             boot_select_out,
  output logic                             boot_port_16,
  output logic [6:0]                       port_c_out,
  output logic [`UPPER_PIN_COUNT-1:0]      cs_match_term
);

  if (ADDR_W < `REG_ADDR_W) begin : g_bad_addr_w
    $error("address width too small for the register map");
  end

  // byte-lane merge, used by both registers
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0]  strb,
                                              input logic [15:0] mask);
    logic [15:0] merged;
    merged = old_val;
    if (strb[0]) begin
      merged[7:0] = new_val[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = new_val[15:8];
    end
    return merged & mask;
  endfunction

  // high bit of each selector: a low strap bit also forces every pin below it
  function automatic logic [`UPPER_PIN_COUNT-1:0] thermo(input logic [4:0] d);
    logic [`UPPER_PIN_COUNT-1:0] hb;
    logic                        run;
    run = 1'b1;
    hb  = '0;
    for (int k = `UPPER_PIN_COUNT - 1; k >= 0; k--) begin
      run   = run & d[k];
      hb[k] = run;
    end
    return hb;
  endfunction

  // ---------------------------------------------------------------- straps
  logic [7:0]   strap_s1;
  logic [7:0]   strap_s2;
  logic [7:0]   strap_s3;
  logic [7:0]   strap_stable;
  strap_state_e strap_state;
  strap_state_e next_strap_state;

  // pins are foreign to aclk; a bit counts only once s2 and s3 agree
  always_ff @(posedge aclk) begin
    strap_s1 <= data_bus_strap;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  wire [7:0] strap_agree = ~(strap_s2 ^ strap_s3);
  wire [7:0] next_strap  = (strap_agree & strap_s3) | (~strap_agree & strap_stable);

  always_ff @(posedge aclk) begin
    strap_stable <= next_strap;
  end

  always_comb begin
    case (strap_state)
      ST_IN_RESET: next_strap_state = ST_LOAD;
      ST_LOAD:     next_strap_state = ST_RUN;
      ST_RUN:      next_strap_state = ST_RUN;
      default:     next_strap_state = ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_state <= ST_IN_RESET;
    end else begin
      strap_state <= next_strap_state;
    end
  end

  wire                        strap_load = (strap_state == ST_LOAD);
  wire [4:0]                  strap_hi   = strap_stable[`STRAP_FIRST_BIT +: 5];
  wire [`UPPER_PIN_COUNT-1:0] strap_hb   = thermo(strap_hi);

  logic [15:0] strap_sel;
  always_comb begin
    strap_sel = '0;
    for (int k = 0; k < `UPPER_PIN_COUNT; k++) begin
      strap_sel[2 * k]     = 1'b1;
      strap_sel[2 * k + 1] = strap_hb[k];
    end
  end

  // --------------------------------------------------------- write channel
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held;
  logic [15:0]       w_data_q;
  logic [1:0]        w_strb_q;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  wire wr_upper = do_write && (aw_addr_q[ADDR_W-1:2] == `UPPER_PIN_FUNCTION_SELECT_IDX);
  wire wr_port_c_output_latch = do_write && (aw_addr_q[ADDR_W-1:2] == `PORT_C_OUTPUT_LATCH_IDX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_q <= s_axi_awaddr;
    end
    if (w_take) begin
      w_data_q <= s_axi_wdata[15:0];
      w_strb_q <= s_axi_wstrb[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_upper || wr_port_c_output_latch) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------- registers
  logic [15:0] upper_pin_function_select;
  logic [7:0]  port_c_output_latch;

  wire [15:0] next_upper = merge_bytes(upper_pin_function_select, w_data_q, w_strb_q,
                                       `UPPER_SEL_MASK);
  wire [15:0] port_c_output_latch_wide = merge_bytes({8'h00, port_c_output_latch}, w_data_q,
                                       {1'b0, w_strb_q[0]}, {8'h00, `PORT_C_MASK});
  wire [7:0]  next_port_c_output_latch = port_c_output_latch_wide[7:0];

  // strap capture wins over a write at the second edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_pin_function_select <= `UPPER_SEL_RESET;
    end else if (strap_load) begin
      upper_pin_function_select <= strap_sel;
    end else if (wr_upper) begin
      upper_pin_function_select <= next_upper;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_output_latch <= `PORT_C_RESET;
    end else if (wr_port_c_output_latch) begin
      port_c_output_latch <= next_port_c_output_latch;
    end
  end

  // boot width is taken once per reset; 8-bit expanded mode ignores the strap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_port_16 <= 1'b0;
    end else if (strap_load) begin
      boot_port_16 <= strap_stable[`BOOT_WIDTH_BIT] && !mode_8bit_expanded;
    end
  end

  // ---------------------------------------------------------- read channel
  wire rd_upper = (s_axi_araddr[ADDR_W-1:2] == `UPPER_PIN_FUNCTION_SELECT_IDX);
  wire rd_port_c_output_latch = (s_axi_araddr[ADDR_W-1:2] == `PORT_C_OUTPUT_LATCH_IDX);
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  // reserved bits already sit at zero in the registers
  wire [31:0] rd_value = rd_upper ? {16'h0000, upper_pin_function_select} :
                         rd_port_c_output_latch ? {24'h000000, port_c_output_latch} :
                                    32'h00000000;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= (rd_upper || rd_port_c_output_latch) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------- pin side
  pin_drive_if pins ();

  always_comb begin
    for (int k = 0; k < `UPPER_PIN_COUNT; k++) begin
      pins.sel[k] = upper_pin_function_select[2 * k +: 2];
    end
  end

  assign pins.port_c    = port_c_output_latch[6:0];
  assign pins.e_clock   = bus_e_clock_out;
  assign pins.addr_high = addr_high_in;
  assign pins.match     = cs_match;

  pin_function_mux #(
    .PIN_COUNT    (`UPPER_PIN_COUNT),
    .HAS_DISCRETE (5'h1F)
  ) u_mux (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (pins.mux)
  );

  assign cs_pin_out = pins.pin_out;
  assign cs_port_16 = pins.port_16;

  // match reporting ignores the pin mode so termination can still be generated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_match_term   <= '0;
      boot_select_out <= 1'b1;
      port_c_out      <= 7'(`PORT_C_RESET);
    end else begin
      cs_match_term   <= cs_match;
      boot_select_out <= !boot_match;
      port_c_out      <= port_c_output_latch[6:0];
    end
  end

  // protection bits carry no meaning for this slave
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16], s_axi_wstrb[3:2]};

endmodule

`default_nettype wire

// >>> testbench/pin_assign_props.sv
// port assertions for the upper pin-function block
// assumes a bind from the bench top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module pin_assign_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // straps and pins
  input wire logic [7:0]  data_bus_strap,
  input wire logic        mode_8bit_expanded,
  input wire logic [4:0]  cs_match,
  input wire logic        boot_match,
  input wire logic [4:0]  cs_pin_out,
  input wire logic [4:0]  cs_port_16,
  input wire logic        boot_select_out,
  input wire logic        boot_port_16,
  input wire logic [6:0]  port_c_out,
  input wire logic [4:0]  cs_match_term
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // only 16-bit pins are visible at the ports, so 8-bit ones rely on the bench
  a_cs16_pin_low: assert property ($past(aresetn) |->
    (((cs_pin_out ^ ~$past(cs_match)) & cs_port_16) == 5'h00)) else $error("pin not low on match");
  a_match_term_any: assert property ($past(aresetn) |->
    cs_match_term == $past(cs_match)) else $error("match lost in pin mode");
  a_boot_follow: assert property ($past(aresetn) |->
    boot_select_out == !$past(boot_match)) else $error("boot select wrong");
  a_reset_state: assert property ($rose(aresetn) |-> cs_pin_out == 5'h1F &&
    port_c_out == 7'h7F && !boot_port_16 && cs_match_term == 5'h00) else $error("reset state");
  // the width is loaded at the second edge after release, so it shows from the third
  a_boot_width_load: assert property ($past(aresetn, 2) && !$past(aresetn, 3) |->
    boot_port_16 == (data_bus_strap[0] && !mode_8bit_expanded)) else $error("boot width");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule

`default_nettype wire

// >>> testbench/ext_strap_model.sv
// data-bus strap levels seen by the pin-function block at reset
// assumes weak pull-ups on every data line; external logic may hold lines low
`timescale 1ns/1ps
`default_nettype none

module ext_strap_model (
  // lines held low by external logic
  input  wire logic [7:0] hold_low,
  // resulting levels on the data bus
  output logic [7:0]      data_bus_strap
);
  // an undriven line floats up to one, so only an explicit hold gives zero
  assign data_bus_strap = ~hold_low;
endmodule

`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the upper pin-function block
// assumes the design package and params header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_params.svh"

module testbench;
  import pin_select_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mode, ecl, bm;
  logic        awready, wready, bvalid, arready, rvalid, boot_sel, boot16;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, pv, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  hold_low, strap, hl;
  logic [4:0]  adr, m, pins, p16, term;
  logic [6:0]  pc_out;
  int          error_cnt, n_checks, cyc;

  ext_strap_model strap_u (.hold_low(hold_low), .data_bus_strap(strap));

  chip_select_pin_assignment dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .data_bus_strap(strap), .mode_8bit_expanded(mode),
    .bus_e_clock_out(ecl), .addr_high_in(adr), .cs_match(m), .boot_match(bm),
    .cs_pin_out(pins), .cs_port_16(p16), .boot_select_out(boot_sel),
    .boot_port_16(boot16), .port_c_out(pc_out), .cs_match_term(term)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [15:0] exp_sel(input logic [7:0] s);
    logic th;
    exp_sel = 16'h0000;
    th = 1'b1;
    for (int k = 4; k >= 0; k--) begin
      th = th & s[k+3];
      exp_sel[2*k+1] = th;
      exp_sel[2*k] = 1'b1;
    end
  endfunction

  function automatic logic [9:0] exp_pin(input logic [15:0] s, input logic [6:0] pc,
                                         input logic e, input logic [4:0] ad, mt);
    logic [4:0] dis;
    dis = {e, pc[6:3]};
    for (int k = 0; k < 5; k++) begin
      exp_pin[k] = (s[2*k+:2] == 2'b00) ? dis[k] : (s[2*k+:2] == 2'b01) ? ad[k] : !mt[k];
      exp_pin[k+5] = (s[2*k+:2] == 2'b11);
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // requests rise after an edge and drop only after the edge that takes them
  task automatic wr(input logic [19:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    // one stall cycle before accepting the response
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = bvalid;
      rs = bresp;
      @(posedge aclk);
    end while (!ta);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = rvalid;
      dt = rdata;
      rs = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask

  task automatic do_reset(input logic [7:0] h, input logic md);
    @(posedge aclk);
    aresetn <= 1'b0;
    hold_low <= h;
    mode <= md;
    // four edges so new straps pass the synchroniser
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // straps land in the select register at the second edge after release
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mode, ecl, bm} = 9'h000;
    {awaddr, araddr, wdata, hold_low, adr, m} = 0;
    void'($urandom(32'hD48A));
    for (int i = 0; i < 8; i++) begin
      hl = (i < 6) ? ((8'h04 << i) | {7'h00, i[0]}) : 8'($urandom);
      do_reset(hl, i == 2);
      rd(`UPPER_PIN_FUNCTION_SELECT_ADDR, d, r);
      chk("strap select", {16'h0000, exp_sel(~hl)}, d);
      chk("boot width", {31'h0, !hl[0] && i != 2}, {31'h0, boot16});
      rd(`PORT_C_OUTPUT_LATCH_ADDR, d, r);
      chk("port c reset", 32'h0000007F, d);
      chk("reset pins", {22'h0, exp_pin(exp_sel(~hl), 7'h7F, 1'b0, 5'h00, 5'h00)}, {22'h0, p16, pins});
    end
    wr(20'h00010, 32'h0000FFFF, r);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    rd(20'h00010, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    for (int i = 0; i < 30; i++) begin
      v = $urandom;
      pv = $urandom;
      wr(`UPPER_PIN_FUNCTION_SELECT_ADDR, v, r);
      rd(`UPPER_PIN_FUNCTION_SELECT_ADDR, d, r);
      chk("select reg", v & 32'h000003FF, d);
      wr(`PORT_C_OUTPUT_LATCH_ADDR, pv, r);
      rd(`PORT_C_OUTPUT_LATCH_ADDR, d, r);
      chk("port c latch", pv & 32'h0000007F, d);
      for (int j = 0; j < 4; j++) begin
        @(posedge aclk);
        ecl <= 1'($urandom);
        bm <= 1'($urandom);
        adr <= 5'($urandom);
        m <= 5'($urandom);
        @(posedge aclk);
        @(negedge aclk);
        chk("pins", {22'h0, exp_pin(v[15:0], pv[6:0], ecl, adr, m)}, {22'h0, p16, pins});
        chk("port c out", pv & 32'h0000007F, {25'h0, pc_out});
      end
    end
    conclude();
  end
endmodule

bind chip_select_pin_assignment pin_assign_props chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .data_bus_strap(data_bus_strap), .mode_8bit_expanded(mode_8bit_expanded),
  .cs_match(cs_match), .boot_match(boot_match), .cs_pin_out(cs_pin_out),
  .cs_port_16(cs_port_16), .boot_select_out(boot_select_out), .boot_port_16(boot_port_16),
  .port_c_out(port_c_out), .cs_match_term(cs_match_term)
);

`default_nettype wire
